//--- via_pkg.sv
// Constants and types shared by the vectored interrupt acknowledge block
package via_pkg;

   // ***********************************************************
   // Sizes
   // ***********************************************************
   localparam int VIA_NUM_SRC = 16;
   localparam int VIA_SRC_W = 4;
   localparam int VIA_NUM_EXT = 4;

   // ***********************************************************
   // Status word layout and reset value
   // ***********************************************************
   localparam int VIA_PSW_IE_BIT = 7;
   localparam int VIA_PSW_ISP_BIT = 1;
   localparam logic [7:0] VIA_PSW_RST = 8'h02;

   // ***********************************************************
   // Vector table
   // ***********************************************************
   localparam logic [15:0] VIA_BRK_VEC = 16'h003e;
   localparam logic [15:0] VIA_VEC_BASE_DEF = 16'h0004;

   // ***********************************************************
   // Least request-to-service times, in CPU clocks
   // ***********************************************************
   localparam int VIA_LAT_HI_CLK = 7;
   localparam int VIA_LAT_LO_CLK = 8;
   localparam int VIA_LAT_BRK_CLK = 4;
   localparam int VIA_CNT_W = 4;

   // ***********************************************************
   // Sequencer states and state record
   // ***********************************************************
   typedef enum logic [1:0] {
      VIA_ST_IDLE,
      VIA_ST_PCH,
      VIA_ST_PCL,
      VIA_ST_WAIT
   } via_seq_t;

   typedef struct packed {
      logic [7:0] program_status_word;
      via_seq_t seq;
      logic [VIA_CNT_W-1:0] cnt;
      logic [VIA_CNT_W-1:0] target;
      logic [15:0] pc_save;
      logic [15:0] vec;
      logic stk_we;
      logic [7:0] stk_data;
      logic pc_load;
      logic ack;
      logic [VIA_SRC_W-1:0] ack_src;
      logic ack_brk;
      logic [VIA_NUM_SRC-1:0] clr;
      logic busy;
      logic [VIA_NUM_EXT-1:0] sync1;
      logic [VIA_NUM_EXT-1:0] sync2;
      logic [VIA_NUM_EXT-1:0] prev;
      logic [VIA_NUM_EXT-1:0] ext_req;
   } via_state_t;

endpackage

//--- via_ack.sv
// Vectored interrupt acknowledge, priority and context push sequencer
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Each edge select pair n routes its port pin to request line n.
// - Status word holds enable and in-service flags; byte, bit, EI, DI access.
// - Maskable accept pushes status then PC, clears enable, copies priority.
// - Status word resets to 02h.
// - Explicit push stores status word; returns and pop restore it.
// - A source is eligible while its request is 1 and mask is 0.
// - Accept only while enable is 1; otherwise the request stays pending.
// - Service starts 7 clocks (high) or 8 clocks (low) at the least.
// - A running divide delays acceptance past the normal latency.
// - Higher programmable priority wins, then fixed default order.
// - A pending request is taken as soon as it becomes acceptable.
// - Break always interrupts: push, clear enable, vector 003eh/003fh.
// - Equal or higher priority nests; lower priority stays pending.
// - After a return, one program instruction runs before a pending accept.
// - High service nests only high; low service nests both; break service nests as the flag it kept allows.
// - In-service flag is 0 in high service, 1 in low service or idle; break leaves it unchanged.
// - Priority bit 0 means high level, 1 means low level.
// - Edge bits: 00 off, 01 falling, 10 rising, 11 both edges.
// - After a flag or status instruction, the next one completes first.
module via_ack
   import via_pkg::*;
#(
   parameter logic [15:0] VEC_BASE = VIA_VEC_BASE_DEF
) (
   input wire logic I_MCLK,
   input wire logic I_RST,
   input wire logic I_CE,
   input wire logic [VIA_NUM_SRC-1:0] I_REQ_FLAG,
   input wire logic [VIA_NUM_SRC-1:0] I_MASK_FLAG,
   input wire logic [VIA_NUM_SRC-1:0] I_PRIO_BIT,
   input wire logic [VIA_NUM_EXT-1:0] I_RISE_SEL,
   input wire logic [VIA_NUM_EXT-1:0] I_FALL_SEL,
   input wire logic [VIA_NUM_EXT-1:0] I_EDGE_PORT,
   input wire logic I_INSN_DONE,
   input wire logic I_HOLD_INSN,
   input wire logic I_DIV_BUSY,
   input wire logic I_BRK,
   input wire logic [15:0] I_PC,
   input wire logic I_EI,
   input wire logic I_DI,
   input wire logic I_PSW_WR,
   input wire logic [7:0] I_PSW_WDATA,
   input wire logic I_PSW_BIT_WR,
   input wire logic [2:0] I_PSW_BIT_SEL,
   input wire logic I_PSW_BIT_VAL,
   input wire logic I_PUSH_PSW,
   input wire logic I_RESTORE_PSW,
   input wire logic [7:0] I_STACK_RDATA,
   output logic [7:0] O_PSW,
   output logic O_STACK_WE,
   output logic [7:0] O_STACK_WDATA,
   output logic O_PC_LOAD,
   output logic [15:0] O_VEC_ADDR,
   output logic O_ACK,
   output logic [VIA_SRC_W-1:0] O_ACK_SRC,
   output logic O_ACK_BRK,
   output logic [VIA_NUM_SRC-1:0] O_REQ_CLR,
   output logic O_BUSY,
   output logic [VIA_NUM_EXT-1:0] O_EXT_PIN_REQ
);

   // ***********************************************************
   // Helpers
   // ***********************************************************

   // Fixed default order: lowest set index wins
   function automatic logic [VIA_SRC_W:0] pick_first(
      input logic [VIA_NUM_SRC-1:0] cand
   );
      logic [VIA_SRC_W:0] res;
      res = '0;
      for (int i = VIA_NUM_SRC - 1; i >= 0; i--) begin
         if (cand[i]) begin
            res = {1'b1, VIA_SRC_W'(i)};
         end
      end
      return res;
   endfunction

   // Least clocks from accept to vector load, minus one
   function automatic logic [VIA_CNT_W-1:0] lat_target(
      input int clk_count
   );
      return VIA_CNT_W'(clk_count - 1);
   endfunction

   // ***********************************************************
   // State
   // ***********************************************************
   via_state_t st_ff;
   via_state_t nxt_st;

   logic [VIA_NUM_SRC-1:0] eligible;
   logic [VIA_NUM_SRC-1:0] cand_hi;
   logic [VIA_NUM_SRC-1:0] cand_lo;
   logic [VIA_SRC_W:0] pick_hi;
   logic [VIA_SRC_W:0] pick_lo;
   logic [VIA_NUM_EXT-1:0] rise_hit;
   logic [VIA_NUM_EXT-1:0] fall_hit;
   logic ie;
   logic in_service_priority_flag;
   logic boundary;
   logic take_hi;
   logic take_lo;
   logic take_brk;
   logic [VIA_SRC_W-1:0] take_src;

   // ***********************************************************
   // Request selection
   // ***********************************************************

   // Eligible sources split by priority level
   assign eligible = I_REQ_FLAG & ~I_MASK_FLAG;
   assign cand_hi = eligible & ~I_PRIO_BIT;
   assign cand_lo = eligible & I_PRIO_BIT;
   assign pick_hi = pick_first(cand_hi);
   assign pick_lo = pick_first(cand_lo);

   assign ie = st_ff.program_status_word[VIA_PSW_IE_BIT];
   assign in_service_priority_flag = st_ff.program_status_word[VIA_PSW_ISP_BIT];

   // Accept only at the end of a non-hold instruction, no divide running
   assign boundary = I_INSN_DONE & ~I_HOLD_INSN & ~I_DIV_BUSY
      & (st_ff.seq == VIA_ST_IDLE);

   // Break beats maskable requests; it cannot be disabled
   assign take_brk = I_INSN_DONE & I_BRK & (st_ff.seq == VIA_ST_IDLE);

   // High level nests whenever enabled; low only outside high service
   assign take_hi = boundary & ~take_brk & ie & pick_hi[VIA_SRC_W];
   assign take_lo = boundary & ~take_brk & ie & ~pick_hi[VIA_SRC_W]
      & pick_lo[VIA_SRC_W] & in_service_priority_flag;

   assign take_src = take_hi ? pick_hi[VIA_SRC_W-1:0]
      : pick_lo[VIA_SRC_W-1:0];

   // ***********************************************************
   // External pin edge detection
   // ***********************************************************
   genvar gi;
   generate
      for (gi = 0; gi < VIA_NUM_EXT; gi++) begin : g_edge
         // Pin n feeds request line n through its own select pair
         assign rise_hit[gi] = st_ff.sync2[gi] & ~st_ff.prev[gi]
            & I_RISE_SEL[gi];
         assign fall_hit[gi] = ~st_ff.sync2[gi] & st_ff.prev[gi]
            & I_FALL_SEL[gi];
      end
   endgenerate

   // ***********************************************************
   // Next state
   // ***********************************************************
   always_comb begin
      nxt_st = st_ff;

      // Pulses default low
      nxt_st.stk_we = 1'b0;
      nxt_st.pc_load = 1'b0;
      nxt_st.ack = 1'b0;
      nxt_st.ack_brk = 1'b0;
      nxt_st.clr = '0;

      // Pin synchroniser and edge pulses
      nxt_st.sync1 = I_EDGE_PORT;
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.prev = st_ff.sync2;
      nxt_st.ext_req = rise_hit | fall_hit;

      unique case (st_ff.seq)
         VIA_ST_IDLE: begin
            // Core-driven status word updates
            if (I_PSW_WR || I_RESTORE_PSW) begin
               nxt_st.program_status_word = I_PSW_WR ? I_PSW_WDATA : I_STACK_RDATA;
            end else if (I_PSW_BIT_WR) begin
               nxt_st.program_status_word[I_PSW_BIT_SEL] = I_PSW_BIT_VAL;
            end else if (I_EI) begin
               nxt_st.program_status_word[VIA_PSW_IE_BIT] = 1'b1;
            end else if (I_DI) begin
               nxt_st.program_status_word[VIA_PSW_IE_BIT] = 1'b0;
            end
            // Explicit push of the status word
            if (I_PUSH_PSW) begin
               nxt_st.stk_we = 1'b1;
               nxt_st.stk_data = st_ff.program_status_word;
            end
            if (take_brk || take_hi || take_lo) begin
               // Push old status word, then disable further accepts
               nxt_st.stk_we = 1'b1;
               nxt_st.stk_data = st_ff.program_status_word;
               nxt_st.program_status_word[VIA_PSW_IE_BIT] = 1'b0;
               nxt_st.pc_save = I_PC;
               nxt_st.cnt = '0;
               nxt_st.busy = 1'b1;
               nxt_st.ack = 1'b1;
               nxt_st.ack_brk = take_brk;
               nxt_st.seq = VIA_ST_PCH;
               if (take_brk) begin
                  nxt_st.vec = VIA_BRK_VEC;
                  nxt_st.target = lat_target(VIA_LAT_BRK_CLK);
               end else begin
                  // Priority bit of the accepted source into in-service flag
                  nxt_st.program_status_word[VIA_PSW_ISP_BIT] = take_lo;
                  nxt_st.ack_src = take_src;
                  nxt_st.clr[take_src] = 1'b1;
                  nxt_st.vec = VEC_BASE
                     + {11'h000, take_src, 1'b0};
                  nxt_st.target = take_hi ? lat_target(VIA_LAT_HI_CLK)
                     : lat_target(VIA_LAT_LO_CLK);
               end
            end
         end
         VIA_ST_PCH: begin
            // Program counter high byte
            nxt_st.stk_we = 1'b1;
            nxt_st.stk_data = st_ff.pc_save[15:8];
            nxt_st.cnt = st_ff.cnt + VIA_CNT_W'(1);
            nxt_st.seq = VIA_ST_PCL;
         end
         VIA_ST_PCL: begin
            // Program counter low byte
            nxt_st.stk_we = 1'b1;
            nxt_st.stk_data = st_ff.pc_save[7:0];
            nxt_st.cnt = st_ff.cnt + VIA_CNT_W'(1);
            nxt_st.seq = VIA_ST_WAIT;
         end
         VIA_ST_WAIT: begin
            // Pad to the least service latency, then branch
            nxt_st.cnt = st_ff.cnt + VIA_CNT_W'(1);
            if (nxt_st.cnt >= st_ff.target) begin
               nxt_st.pc_load = 1'b1;
               nxt_st.busy = 1'b0;
               nxt_st.seq = VIA_ST_IDLE;
            end
         end
      endcase
   end

   // ***********************************************************
   // Registers
   // ***********************************************************
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         st_ff <= '0;
         st_ff.program_status_word <= VIA_PSW_RST;
         st_ff.seq <= VIA_ST_IDLE;
      end else if (I_CE) begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from the state record
   assign O_PSW = st_ff.program_status_word;
   assign O_STACK_WE = st_ff.stk_we;
   assign O_STACK_WDATA = st_ff.stk_data;
   assign O_PC_LOAD = st_ff.pc_load;
   assign O_VEC_ADDR = st_ff.vec;
   assign O_ACK = st_ff.ack;
   assign O_ACK_SRC = st_ff.ack_src;
   assign O_ACK_BRK = st_ff.ack_brk;
   assign O_REQ_CLR = st_ff.clr;
   assign O_BUSY = st_ff.busy;
   assign O_EXT_PIN_REQ = st_ff.ext_req;

endmodule // via_ack
`default_nettype wire

//--- via_ack_asserts.sv
// Port checks for the interrupt acknowledge block
`timescale 1ns/1ps
`default_nettype none
module via_ack_asserts
   import via_pkg::*;
#(
   parameter logic [15:0] VEC_BASE = VIA_VEC_BASE_DEF
) (
   input wire logic I_MCLK,
   input wire logic I_RST,
   input wire logic [VIA_NUM_SRC-1:0] I_REQ_FLAG,
   input wire logic [VIA_NUM_SRC-1:0] I_MASK_FLAG,
   input wire logic [VIA_NUM_SRC-1:0] I_PRIO_BIT,
   input wire logic [7:0] O_PSW,
   input wire logic O_STACK_WE,
   input wire logic [7:0] O_STACK_WDATA,
   input wire logic O_PC_LOAD,
   input wire logic [15:0] O_VEC_ADDR,
   input wire logic O_ACK,
   input wire logic [VIA_SRC_W-1:0] O_ACK_SRC,
   input wire logic O_ACK_BRK
);
   // ****
   // Request state seen at the accept edge
   // ****
   logic [VIA_NUM_SRC-1:0] elig_ff;
   logic [VIA_NUM_SRC-1:0] prio_ff;
   logic mack;
   always_ff @(posedge I_MCLK) begin
      elig_ff <= I_REQ_FLAG & ~I_MASK_FLAG;
      prio_ff <= I_PRIO_BIT;
   end
   assign mack = O_ACK && !O_ACK_BRK;
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_RST);
   a_stack_order: assert property (O_ACK |-> O_STACK_WE [*3])
      else $error("context push not three bytes");
   a_stack_psw: assert property (O_ACK |-> O_STACK_WDATA == $past(O_PSW))
      else $error("first pushed byte not status");
   a_ack_ie_off: assert property (O_ACK |-> !O_PSW[VIA_PSW_IE_BIT])
      else $error("enable not cleared on accept");
   a_ack_ie_on: assert property (mack |-> $past(O_PSW[VIA_PSW_IE_BIT]))
      else $error("accept while disabled");
   a_ack_elig: assert property (mack |-> elig_ff[O_ACK_SRC])
      else $error("accepted source not eligible");
   a_isp_copy: assert property (mack |->
      O_PSW[VIA_PSW_ISP_BIT] == prio_ff[O_ACK_SRC])
      else $error("in-service flag not copied");
   a_low_nest: assert property (mack && prio_ff[O_ACK_SRC] |->
      $past(O_PSW[VIA_PSW_ISP_BIT]) && !(|(elig_ff & ~prio_ff)))
      else $error("low source taken wrongly");
   a_hi_load: assert property (mack && !O_PSW[VIA_PSW_ISP_BIT] |->
      !O_PC_LOAD [*6] ##1 O_PC_LOAD)
      else $error("high service start not at 7");
   a_lo_load: assert property (mack && O_PSW[VIA_PSW_ISP_BIT] |->
      !O_PC_LOAD [*7] ##1 O_PC_LOAD)
      else $error("low service start not at 8");
   a_brk_load: assert property (O_ACK && O_ACK_BRK |->
      ##3 O_PC_LOAD && O_VEC_ADDR == VIA_BRK_VEC)
      else $error("break vector wrong");
endmodule // via_ack_asserts
bind via_ack via_ack_asserts #(.VEC_BASE(VEC_BASE)) u_chk (.I_MCLK,
   .I_RST, .I_REQ_FLAG, .I_MASK_FLAG, .I_PRIO_BIT, .O_PSW, .O_STACK_WE,
   .O_STACK_WDATA, .O_PC_LOAD, .O_VEC_ADDR, .O_ACK, .O_ACK_SRC, .O_ACK_BRK);
`default_nettype wire

//--- via_core_model.sv
// Core sequencer and request sources beside the acknowledge block
`timescale 1ns/1ps
`default_nettype none
module via_core_model
   import via_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_gap,
   input wire logic i_busy,
   input wire logic [VIA_NUM_SRC-1:0] i_set,
   input wire logic [VIA_NUM_SRC-1:0] i_clr,
   output logic o_done,
   output logic [15:0] o_pc,
   output logic [VIA_NUM_SRC-1:0] o_req
);
   // ****
   // Instruction pacing and request flags
   // ****
   logic [3:0] cnt_ff;
   // One instruction ends every i_gap+1 clocks, none during a push
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_ff <= 4'h0;
         o_pc <= 16'h1000;
         o_req <= '0;
      end else begin
         cnt_ff <= (o_done || i_busy) ? 4'h0 : cnt_ff + 4'h1;
         o_pc <= o_done ? o_pc + 16'h0002 : o_pc;
         o_req <= (o_req | i_set) & ~i_clr; // Flag stays until cleared
      end
   end
   assign o_done = !i_busy && cnt_ff == i_gap;
endmodule // via_core_model
`default_nettype wire

//--- test_via_ack.sv
// Self-checking bench for the interrupt acknowledge block
`timescale 1ns/1ps
`default_nettype none
module test_via_ack
   import via_pkg::*;
();
   logic clk, rst, ei, di, wr, bwr, bval, push, rest, software_break_instruction, hold, div;
   logic done, busy, swe, pcl, ack, abrk;
   logic [2:0] bsel;
   logic [3:0] rise, fall, pin, gap, asrc, ext;
   logic [7:0] wdata, rdata, program_status_word, sdata;
   logic [15:0] mask, prio, set, drop, req, pc, clr, vec;
   int errors, n_tests, cyc, nack, npul[4];
   via_core_model core (.i_clk(clk), .i_rst(rst), .i_gap(gap),
      .i_busy(busy), .i_set(set), .i_clr(clr | drop), .o_done(done),
      .o_pc(pc), .o_req(req));
   via_ack uut (.I_MCLK(clk), .I_RST(rst), .I_CE(1'b1), .I_REQ_FLAG(req),
      .I_MASK_FLAG(mask), .I_PRIO_BIT(prio), .I_RISE_SEL(rise),
      .I_FALL_SEL(fall), .I_EDGE_PORT(pin), .I_INSN_DONE(done),
      .I_HOLD_INSN(hold), .I_DIV_BUSY(div), .I_BRK(software_break_instruction), .I_PC(pc),
      .I_EI(ei), .I_DI(di), .I_PSW_WR(wr), .I_PSW_WDATA(wdata),
      .I_PSW_BIT_WR(bwr), .I_PSW_BIT_SEL(bsel), .I_PSW_BIT_VAL(bval),
      .I_PUSH_PSW(push), .I_RESTORE_PSW(rest), .I_STACK_RDATA(rdata),
      .O_PSW(program_status_word), .O_STACK_WE(swe), .O_STACK_WDATA(sdata),
      .O_PC_LOAD(pcl), .O_VEC_ADDR(vec), .O_ACK(ack), .O_ACK_SRC(asrc),
      .O_ACK_BRK(abrk), .O_REQ_CLR(clr), .O_BUSY(busy),
      .O_EXT_PIN_REQ(ext));
   // ****
   // Clock, watchdog and pulse counters
   // ****
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      nack += int'(ack === 1'b1);
      foreach (npul[n]) npul[n] += int'(ext[n] === 1'b1);
      if (cyc == 3000) begin
         errors++;
         $display("unexpected timeout at %0t", $time);
         finish_test();
      end
   end
   task automatic step(int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("unexpected value at %0t: %h not %h", $time, got, exp);
      end
   endtask
   // One-clock core strobe: ei di wr bwr push rest
   task automatic op(logic [5:0] s);
      {ei, di, wr, bwr, push, rest} = s;
      step();
      {ei, di, wr, bwr, push, rest} = '0;
   endtask
   task automatic quiet(int n);
      int k;
      k = nack;
      step(n);
      chk(16'(nack - k), 16'h0000);
   endtask
   // Wait for an accept, check source, flags and vector
   task automatic take(logic b, logic [3:0] src, logic [7:0] px);
      int i;
      i = 0;
      while (ack !== 1'b1 && i < 60) begin
         step();
         i++;
      end
      software_break_instruction = 1'b0;
      chk(16'(abrk), 16'(b));
      if (!b) chk(16'(asrc), 16'(src));
      chk(16'(program_status_word), 16'(px));
      step(9);
      chk(vec, b ? VIA_BRK_VEC : VIA_VEC_BASE_DEF + {src, 1'b0});
   endtask
   task automatic finish_test();
      $display("errors %0d comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ****
   // Test sequence
   // ****
   initial begin
      {ei, di, wr, bwr, bval, push, rest, software_break_instruction, hold, div} = '0;
      {bsel, wdata, rdata, rise, fall, pin, mask, set, drop} = '0;
      {errors, n_tests, cyc, nack} = '0;
      npul = '{default: 0};
      prio = 16'h0200;
      gap = 4'h2;
      rst = 1'b1;
      step(12);
      rst = 1'b0;
      chk(16'(program_status_word), 16'h0002);
      set = 16'h0214;
      step();
      set = '0;
      quiet(20);
      hold = 1'b1;
      op(6'h20);
      quiet(20);
      hold = 1'b0;
      take(0, 4'h2, 8'h00);
      op(6'h20);
      take(0, 4'h4, 8'h00);
      op(6'h20);
      quiet(20);
      rdata = 8'h82;
      op(6'h01);
      take(0, 4'h9, 8'h02);
      mask = 16'h0040;
      set = 16'h0040;
      op(6'h20);
      set = '0;
      quiet(20);
      mask = '0;
      div = 1'b1;
      quiet(20);
      div = 1'b0;
      take(0, 4'h6, 8'h00);
      gap = 4'h0;
      software_break_instruction = 1'b1;
      take(1, 4'h0, 8'h00);
      wdata = 8'h82;
      op(6'h08);
      chk(16'(program_status_word), 16'h0082);
      op(6'h10);
      chk(16'(program_status_word), 16'h0002);
      bsel = 3'h7;
      bval = 1'b1;
      op(6'h04);
      chk(16'(program_status_word), 16'h0082);
      op(6'h02);
      chk(16'({swe, sdata}), 16'h0182);
      for (int m = 0; m < 16; m++) begin
         rise = 4'(m[1]) << m[3:2];
         fall = 4'(m[0]) << m[3:2];
         step(2);
         npul = '{default: 0};
         pin[m[3:2]] = 1'b1;
         step(6);
         pin[m[3:2]] = 1'b0;
         step(6);
         chk(16'(npul[m[3:2]]), 16'(m[1]) + 16'(m[0]));
         chk(16'(npul.sum()), 16'(m[1]) + 16'(m[0]));
      end
      rise = '0;
      fall = '0;
      step(4);
      finish_test();
   end
endmodule // test_via_ack
`default_nettype wire
